/* File: tb/frc_assertions.sv */
// Port checker for the fault retry block
`timescale 1ns/100ps
`default_nettype none
module frc_assertions (
  // Clock, reset and command port
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic cmd_wr_i,
  input wire logic cmd_rd_i,
  input wire logic [7:0] cmd_code_i,
  input wire logic [7:0] cmd_rdata_o,
  input wire logic cmd_ack_o,
  // Channel state, status and lines
  input wire logic [1:0] local_fault_i,
  input wire logic [1:0] chan_enable_o,
  input wire logic [1:0] faulted_off_o,
  input wire logic [1:0] mfr_line_stat_ch0_o,
  input wire logic [1:0] mfr_line_stat_ch1_o,
  input wire logic host_alert_line_n_o,
  input wire logic shared_fault_line_0_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);
  // Decoded request kinds
  wire logic req = cmd_wr_i | cmd_rd_i;
  wire logic known = cmd_code_i inside {8'hd2, 8'hd3, 8'hd4, 8'hd5, 8'hd6};
  // Local fault while running, then the channel off and marked faulted
  sequence s_hit;
    local_fault_i[0] && chan_enable_o[0];
  endsequence
  sequence s_down;
    !chan_enable_o[0] && faulted_off_o[0];
  endsequence
  a_ack_known: assert property (req && known |=> cmd_ack_o)
    else $error("known code not acknowledged");
  a_unknown_quiet: assert property (req && !known |=> !cmd_ack_o && cmd_rdata_o == 8'h00)
    else $error("unknown code answered");
  a_rdata_idle: assert property (!cmd_rd_i |=> cmd_rdata_o == 8'h00)
    else $error("read data without read");
  a_retry_upper: assert property (cmd_rd_i && cmd_code_i == 8'hd4 |=> cmd_rdata_o[7:3] == 5'h00)
    else $error("retry count upper bits set");
  a_prop_upper: assert property (cmd_rd_i && cmd_code_i inside {8'hd2, 8'hd3} |=> cmd_rdata_o[7:1] == 7'h00)
    else $error("propagate reserved bits set");
  a_resp_upper: assert property (cmd_rd_i && cmd_code_i inside {8'hd5, 8'hd6} |=> cmd_rdata_o[7:2] == 6'h00)
    else $error("response reserved bits set");
  a_alert_tracks: assert property (host_alert_line_n_o == !(|{mfr_line_stat_ch1_o, mfr_line_stat_ch0_o}))
    else $error("alert does not follow status");
  a_line_low_only: assert property (shared_fault_line_0_o == 1'b0)
    else $error("fault line driven high");
  a_fault_stop: assert property (s_hit |-> ##[1:3] s_down)
    else $error("local fault left channel running");
  a_stat_shut: assert property ($rose(mfr_line_stat_ch0_o[0]) |-> !chan_enable_o[0])
    else $error("line status set while running");
endmodule // frc_assertions
bind frc_top frc_assertions chk_u (.sys_clk_i, .sys_rst_i, .cmd_wr_i, .cmd_rd_i, .cmd_code_i,
  .cmd_rdata_o, .cmd_ack_o, .local_fault_i, .chan_enable_o, .faulted_off_o, .mfr_line_stat_ch0_o,
  .mfr_line_stat_ch1_o, .host_alert_line_n_o, .shared_fault_line_0_o);
`default_nettype wire

/* File: tb/frc_peer.sv */
// Model of the other managers sharing the two wired fault lines
`timescale 1ns/100ps
`default_nettype none
module frc_peer (
  // Pulls commanded by the bench on behalf of other managers
  input wire logic [1:0] pull_i,
  // Our device pulling the lines
  input wire logic [1:0] dut_oe_i,
  // Resolved line levels
  output logic [1:0] line_o
);
  // Pull-up wins only when nobody pulls; no party ever drives high
  assign line_o = ~(pull_i | dut_oe_i);
endmodule // frc_peer
`default_nettype wire

/* File: tb/frc_top_tb.sv */
// Self-checking bench for the fault retry block
`timescale 1ns/100ps
`default_nettype none
module frc_top_tb;
  logic sys_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic wr = 0, rd = 0, pg = 0, nvl = 0, sclr = 0, ack, alert, pe = 0;
  logic [7:0] code = 8'h00, wd = 8'h00, rdat;
  logic [39:0] nv = 40'h0;
  logic [1:0] on = 0, lf = 0, pull = 0, en, fo, st0, st1, oe, ln;
  logic [5:0] fld = 6'h00;
  logic [15:0] dly = 16'h0000;
  logic [7:0] mdl [0:15];
  integer seed = 41, n_fail = 0, n_tests = 0, rises = 0, i, j, k;
  integer lim [0:5] = '{0, 2, 6, 7, 3, 1};
  integer nf [0:5] = '{2, 4, 8, 9, 2, 3};
  integer fz [0:5] = '{0, 0, 0, 0, 1, 0};
  integer qt [0:5] = '{0, 0, 0, 0, 0, 1};
  // Short counts keep the quiet and qualification times affordable
  frc_top #(.QUAL_CYC(8), .QUIET_CYC(2000), .STEP_CYC(4)) dut_u (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
    .cmd_wr_i(wr), .cmd_rd_i(rd), .cmd_code_i(code), .cmd_page_i(pg), .cmd_wdata_i(wd), .cmd_rdata_o(rdat),
    .cmd_ack_o(ack), .nv_load_i(nvl), .nv_prop0_i(nv[7:0]), .nv_prop1_i(nv[15:8]), .nv_resp0_i(nv[23:16]),
    .nv_resp1_i(nv[31:24]), .nv_retry_i(nv[39:32]), .chan_on_cmd_i(on), .local_fault_i(lf),
    .fault_retry_field_i(fld), .retry_delay_steps_i(dly), .status_clear_i(sclr), .shared_fault_line_0_i(ln[0]),
    .shared_fault_line_1_i(ln[1]), .shared_fault_line_0_o(), .shared_fault_line_0_oe_o(oe[0]),
    .shared_fault_line_1_o(), .shared_fault_line_1_oe_o(oe[1]), .chan_enable_o(en), .faulted_off_o(fo),
    .mfr_line_stat_ch0_o(st0), .mfr_line_stat_ch1_o(st1), .host_alert_line_n_o(alert));
  frc_peer peer_u (.pull_i(pull), .dut_oe_i(oe), .line_o(ln));
  // Clock
  initial forever #10 sys_clk_i = ~sys_clk_i;
  // Count channel 0 restarts, sampled away from the launching edge
  always @(negedge sys_clk_i) begin
    if (en[0] === 1'b1 && pe === 1'b0) rises = rises + 1;
    pe = en[0];
  end
  function logic known(input logic [7:0] c);
    known = c inside {8'hd2, 8'hd3, 8'hd4, 8'hd5, 8'hd6};
  endfunction
  function logic [7:0] msk(input logic [7:0] c);
    msk = c < 8'hd4 ? 8'h01 : (c == 8'hd4 ? 8'h07 : 8'h03);
  endfunction
  // Only the propagate bytes are paged
  function integer ix(input logic [7:0] c, input logic p);
    ix = {c[2:0], p & (c < 8'hd4)};
  endfunction
  task chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests = n_tests + 1;
    if (got !== exp) begin
      n_fail = n_fail + 1;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task cyc(input integer n);
    repeat (n) @(negedge sys_clk_i);
  endtask
  task give_verdict;
    $display("tests %0d failures %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task do_reset;
    sys_rst_i = 1;
    on = 0;
    cyc(3);
    sys_rst_i = 0;
    for (i = 0; i < 16; i = i + 1) mdl[i] = 8'h00;
  endtask
  // One byte access; answer is due in the cycle after the strobe
  task acc(input logic w, input logic [7:0] c, input logic p, input logic [7:0] d);
    @(negedge sys_clk_i);
    wr = w;
    rd = !w;
    code = c;
    pg = p;
    wd = d;
    @(negedge sys_clk_i);
    wr = 0;
    rd = 0;
    chk(ack, known(c));
    chk(rdat, (!w && known(c)) ? mdl[ix(c, p)] : 8'h00);
    if (w && known(c)) mdl[ix(c, p)] = d & msk(c);
  endtask
  // Hang guard, well beyond the expected run
  initial begin
    #1000000;
    n_fail = n_fail + 1;
    give_verdict();
  end
  initial begin
    do_reset();
    // Reset values first, then random traffic with unknown codes mixed in
    for (i = 0; i < 70; i = i + 1) begin
      k = $random(seed);
      acc(i < 10 ? 1'b0 : k[0], 8'hd2 + (i < 10 ? i % 5 : k[10:8]), i < 10 ? i / 5 : k[1], k[23:16]);
    end
    nv = {$random(seed), $random(seed)};
    nvl = 1;
    cyc(1);
    nvl = 0;
    {mdl[4], mdl[5], mdl[6], mdl[7]} = {{2{7'h0, nv[0]}}, {2{7'h0, nv[8]}}};
    {mdl[8], mdl[10], mdl[12]} = {nv[39:32] & 8'h07, nv[23:16] & 8'h03, nv[31:24] & 8'h03};
    for (i = 0; i < 10; i = i + 1) acc(0, 8'hd2 + i / 2, i % 2, 8'h00);
    do_reset();
    // Faulted-off channels pull their enabled lines; limit 0 keeps them off
    acc(1, 8'hd2, 0, 8'hff);
    acc(1, 8'hd3, 1, 8'h01);
    on = 2'b11;
    cyc(5);
    for (i = 0; i < 2; i = i + 1) begin
      lf[i] = 1;
      cyc(4);
      lf[i] = 0;
      cyc(2);
      chk({fo, oe, ln}, {i ? 6'h3c : 6'h16});
    end
    acc(1, 8'hd2, 0, 8'h00);
    acc(1, 8'hd3, 1, 8'h00);
    on = 2'b00;
    // Retry limit table: count restarts of channel 0 across repeated faults
    for (i = 0; i < 6; i = i + 1) begin
      k = $random(seed);
      acc(1, 8'hd4, 0, {k[7:3], lim[i][2:0]});
      fld = {3'h0, fz[i] ? 3'h0 : (k[10:8] | 3'h1)};
      dly = {14'h0, k[17:16]};
      on[0] = 0;
      cyc(3);
      on[0] = 1;
      cyc(6);
      rises = 0;
      for (j = 0; j < nf[i]; j = j + 1) begin
        lf[0] = 1;
        cyc(1);
        lf[0] = 0;
        cyc(qt[i] ? 2100 : 40);
      end
      chk(rises, fz[i] ? 0 : ((qt[i] || lim[i] == 7 || nf[i] < lim[i]) ? nf[i] : lim[i]));
    end
    // Line response: latched only at off-then-on, qualified, then restart
    on = 2'b00;
    cyc(3);
    for (i = 0; i < 2; i = i + 1) begin
      on = 2'b11;
      cyc(6);
      acc(1, 8'hd5 + i, 0, 8'hfc | (8'h01 << i));
      pull[i] = 1;
      cyc(30);
      chk(en, 2'b11);
      pull[i] = 0;
      on = 2'b00;
      cyc(3);
      on = 2'b11;
      cyc(6);
      pull[i] = 1;
      cyc(5);
      pull[i] = 0;
      cyc(4);
      chk(en, 2'b11);
      pull[i] = 1;
      cyc(30);
      chk({1'b0, en, st1, st0, alert}, {1'b0, ~(2'b01 << i), 4'b0001 << (3 * i), 1'b0});
      pull[i] = 0;
      cyc(8);
      chk(en, 2'b11);
      sclr = 1;
      cyc(1);
      sclr = 0;
      cyc(2);
      chk(alert, 1'b1);
      on = 2'b00;
      cyc(3);
    end
    give_verdict();
  end
endmodule // frc_top_tb
`default_nettype wire

/* File: verilog/frc_chan.v */
// One channel: retry accounting, fault-line shutdown and restart
`timescale 1ns/100ps
`default_nettype none
`include "frc_defines.vh"
module frc_chan #(
  parameter [31:0] QUIET_CYC = `FRC_QUIET_CYC,
  parameter [31:0] STEP_CYC = `FRC_STEP_CYC
) (
  // Clock and reset
  input wire sys_clk_i,
  input wire sys_rst_i,
  // Channel control
  input wire chan_on_cmd_i,
  input wire local_fault_i,
  input wire [2:0] fault_retry_field_i,
  input wire [15:0] retry_delay_steps_i,
  input wire [`FRC_RETRY_W-1:0] retry_limit_i,
  input wire [1:0] line_resp_i,
  input wire [1:0] line_qual_low_i,
  input wire [1:0] line_low_i,
  // Channel state
  output reg chan_enable_o,
  output reg faulted_off_o,
  output reg line_shutdown_o,
  output reg [1:0] line_shut_event_o,
  output reg [`FRC_RETRY_W-1:0] retries_used_o
);

  reg prev_on;
  reg [`FRC_RETRY_W-1:0] lim_act;
  reg [1:0] resp_act;
  reg [31:0] quiet_cnt;
  reg [31:0] step_cnt;
  reg [15:0] delay_cnt;
  reg retry_wait;
  wire [15:0] delay_lim;
  wire retry_ok;
  wire [1:0] shut_hit;

  // Interval capped at the largest count of 200 us steps
  assign delay_lim = (retry_delay_steps_i > `FRC_MAX_DELAY_STEPS) ? `FRC_MAX_DELAY_STEPS : retry_delay_steps_i;
  assign retry_ok = (fault_retry_field_i != `FRC_RETRY_NONE) && (lim_act != `FRC_RETRY_NONE) &&
    ((lim_act == `FRC_RETRY_INF) || (retries_used_o < lim_act));
  assign shut_hit = resp_act & line_qual_low_i;

  // Main channel sequencing
  always @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      prev_on <= 1'b0;
      lim_act <= `FRC_RETRY_NONE;
      resp_act <= 2'h0;
      quiet_cnt <= 32'h0;
      step_cnt <= 32'h0;
      delay_cnt <= 16'h0;
      retry_wait <= 1'b0;
      chan_enable_o <= 1'b0;
      faulted_off_o <= 1'b0;
      line_shutdown_o <= 1'b0;
      line_shut_event_o <= 2'h0;
      retries_used_o <= `FRC_RETRY_NONE;
    end else begin
      prev_on <= chan_on_cmd_i;
      line_shut_event_o <= 2'h0;
      if (!chan_on_cmd_i) begin
        chan_enable_o <= 1'b0;
        faulted_off_o <= 1'b0;
        line_shutdown_o <= 1'b0;
        retry_wait <= 1'b0;
      end else if (!prev_on) begin
        // Off-then-on: clear count, adopt new settings
        retries_used_o <= `FRC_RETRY_NONE;
        lim_act <= retry_limit_i;
        resp_act <= line_resp_i;
        chan_enable_o <= 1'b1;
        quiet_cnt <= 32'h0;
      end else if (local_fault_i && chan_enable_o) begin
        chan_enable_o <= 1'b0;
        faulted_off_o <= 1'b1;
        retry_wait <= retry_ok;
        step_cnt <= 32'h0;
        delay_cnt <= 16'h0;
      end else if (retry_wait) begin
        // Interval counted in whole 200 us steps
        if (step_cnt >= STEP_CYC - 32'h1) begin
          step_cnt <= 32'h0;
          if (delay_cnt >= delay_lim) begin
            retry_wait <= 1'b0;
            faulted_off_o <= 1'b0;
            chan_enable_o <= 1'b1;
            quiet_cnt <= 32'h0;
            if (lim_act != `FRC_RETRY_INF)
              retries_used_o <= retries_used_o + 3'h1;
          end else begin
            delay_cnt <= delay_cnt + 16'h1;
          end
        end else begin
          step_cnt <= step_cnt + 32'h1;
        end
      end else if (chan_enable_o && (shut_hit != 2'h0)) begin
        chan_enable_o <= 1'b0;
        line_shutdown_o <= 1'b1;
        line_shut_event_o <= shut_hit;
      end else if (line_shutdown_o && ((resp_act & line_low_i) == 2'h0)) begin
        // Restart; the power stage applies its turn-on delay and rise
        line_shutdown_o <= 1'b0;
        chan_enable_o <= 1'b1;
      end
      // Quiet timer clears the count after 16 s not faulted off
      if (faulted_off_o || !chan_on_cmd_i) begin
        quiet_cnt <= 32'h0;
      end else if (quiet_cnt >= QUIET_CYC - 32'h1) begin
        retries_used_o <= `FRC_RETRY_NONE;
      end else begin
        quiet_cnt <= quiet_cnt + 32'h1;
      end
    end
  end

endmodule // frc_chan
`default_nettype wire

/* File: verilog/frc_defines.vh */
// Register codes, field positions, reset values and timing constants for the fault retry block
`ifndef FRC_DEFINES_VH
`define FRC_DEFINES_VH

// Command codes
`define FRC_CMD_PROP0 8'hd2
`define FRC_CMD_PROP1 8'hd3
`define FRC_CMD_RESP0 8'hd5
`define FRC_CMD_RESP1 8'hd6
`define FRC_CMD_RETRY 8'hd4

// Reset values
`define FRC_RST_BYTE 8'h00
`define FRC_RST_RETRY 3'h0

// Field positions and widths
`define FRC_PROP_BIT 0
`define FRC_RETRY_W 3
`define FRC_RESP_W 2

// Retry count encodings
`define FRC_RETRY_NONE 3'h0
`define FRC_RETRY_INF 3'h7

// Times, in their own units
`define FRC_CLK_MHZ 50
`define FRC_QUAL_US 10
`define FRC_QUIET_S 16
`define FRC_STEP_US 200
`define FRC_MAX_DELAY_STEPS 16'hffdc

// Derived cycle counts
`define FRC_QUAL_CYC (`FRC_QUAL_US * `FRC_CLK_MHZ)
`define FRC_QUIET_CYC (`FRC_QUIET_S * 1000000 * `FRC_CLK_MHZ)
`define FRC_STEP_CYC (`FRC_STEP_US * `FRC_CLK_MHZ)

`endif

/* File: verilog/frc_sync.v */
// Two flip-flop synchroniser for one asynchronous level
`timescale 1ns/100ps
`default_nettype none
module frc_sync (
  // Clock and reset
  input wire sys_clk_i,
  input wire sys_rst_i,
  // Level in and out
  input wire async_i,
  output reg sync_o
);

  reg meta;

  // Idle level of the open-drain line is high
  always @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      meta <= 1'b1;
      sync_o <= 1'b1;
    end else begin
      meta <= async_i;
      sync_o <= meta;
    end
  end

endmodule // frc_sync
`default_nettype wire

/* File: verilog/frc_top.v */
// Fault retry limit and shared fault-line logic for a two-channel power manager
`timescale 1ns/100ps
`default_nettype none
`include "frc_defines.vh"
module frc_top #(
  parameter [31:0] QUAL_CYC = `FRC_QUAL_CYC,
  parameter [31:0] QUIET_CYC = `FRC_QUIET_CYC,
  parameter [31:0] STEP_CYC = `FRC_STEP_CYC
) (
  // Clock and reset
  input wire sys_clk_i,
  input wire sys_rst_i,
  // Command port (byte register access)
  input wire cmd_wr_i,
  input wire cmd_rd_i,
  input wire [7:0] cmd_code_i,
  input wire cmd_page_i,
  input wire [7:0] cmd_wdata_i,
  output reg [7:0] cmd_rdata_o,
  output reg cmd_ack_o,
  // Nonvolatile restore
  input wire nv_load_i,
  input wire [7:0] nv_prop0_i,
  input wire [7:0] nv_prop1_i,
  input wire [7:0] nv_resp0_i,
  input wire [7:0] nv_resp1_i,
  input wire [7:0] nv_retry_i,
  // Channel controls
  input wire [1:0] chan_on_cmd_i,
  input wire [1:0] local_fault_i,
  input wire [5:0] fault_retry_field_i,
  input wire [15:0] retry_delay_steps_i,
  input wire status_clear_i,
  // Shared fault lines, open drain
  input wire shared_fault_line_0_i,
  input wire shared_fault_line_1_i,
  output wire shared_fault_line_0_o,
  output wire shared_fault_line_0_oe_o,
  output wire shared_fault_line_1_o,
  output wire shared_fault_line_1_oe_o,
  // Channel state and host alert
  output wire [1:0] chan_enable_o,
  output wire [1:0] faulted_off_o,
  output reg [1:0] mfr_line_stat_ch0_o,
  output reg [1:0] mfr_line_stat_ch1_o,
  output wire host_alert_line_n_o
);

  reg [1:0] prop0;
  reg [1:0] prop1;
  reg [`FRC_RESP_W-1:0] resp0;
  reg [`FRC_RESP_W-1:0] resp1;
  reg [`FRC_RETRY_W-1:0] retry_lim;
  reg [31:0] qual_cnt0;
  reg [31:0] qual_cnt1;
  wire line0_s;
  wire line1_s;
  wire [1:0] qual_low;
  wire [1:0] ch_fo;
  wire [1:0] ev0;
  wire [1:0] ev1;
  wire [2:0] used0;
  wire [2:0] used1;

  // Register writes; reserved bits are never stored
  always @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      prop0 <= 2'h0;
      prop1 <= 2'h0;
      resp0 <= 2'h0;
      resp1 <= 2'h0;
      retry_lim <= `FRC_RST_RETRY;
    end else if (nv_load_i) begin
      // Nonvolatile copy restored on request
      prop0 <= {nv_prop0_i[`FRC_PROP_BIT], nv_prop0_i[`FRC_PROP_BIT]};
      prop1 <= {nv_prop1_i[`FRC_PROP_BIT], nv_prop1_i[`FRC_PROP_BIT]};
      resp0 <= nv_resp0_i[`FRC_RESP_W-1:0];
      resp1 <= nv_resp1_i[`FRC_RESP_W-1:0];
      retry_lim <= nv_retry_i[`FRC_RETRY_W-1:0];
    end else if (cmd_wr_i) begin
      case (cmd_code_i)
        `FRC_CMD_PROP0: prop0[cmd_page_i] <= cmd_wdata_i[`FRC_PROP_BIT];
        `FRC_CMD_PROP1: prop1[cmd_page_i] <= cmd_wdata_i[`FRC_PROP_BIT];
        `FRC_CMD_RESP0: resp0 <= cmd_wdata_i[`FRC_RESP_W-1:0];
        `FRC_CMD_RESP1: resp1 <= cmd_wdata_i[`FRC_RESP_W-1:0];
        `FRC_CMD_RETRY: retry_lim <= cmd_wdata_i[`FRC_RETRY_W-1:0];
        default: ;
      endcase
    end
  end

  // Read data registered; unknown codes read zero and are not acknowledged
  always @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      cmd_rdata_o <= `FRC_RST_BYTE;
      cmd_ack_o <= 1'b0;
    end else begin
      cmd_ack_o <= 1'b0;
      cmd_rdata_o <= `FRC_RST_BYTE;
      if (cmd_rd_i || cmd_wr_i) begin
        cmd_ack_o <= 1'b1;
        case (cmd_code_i)
          `FRC_CMD_PROP0: cmd_rdata_o <= {7'h00, prop0[cmd_page_i]};
          `FRC_CMD_PROP1: cmd_rdata_o <= {7'h00, prop1[cmd_page_i]};
          `FRC_CMD_RESP0: cmd_rdata_o <= {6'h00, resp0};
          `FRC_CMD_RESP1: cmd_rdata_o <= {6'h00, resp1};
          `FRC_CMD_RETRY: cmd_rdata_o <= {5'h00, retry_lim};
          default: cmd_ack_o <= 1'b0;
        endcase
        // A write is acknowledged but returns no data; rdata stays zero unless read
        if (!cmd_rd_i)
          cmd_rdata_o <= `FRC_RST_BYTE;
      end
    end
  end

  // Fault lines pass two flops before any logic reads them
  frc_sync u_sync0 (
    .sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i),
    .async_i(shared_fault_line_0_i),
    .sync_o(line0_s)
  );
  frc_sync u_sync1 (
    .sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i),
    .async_i(shared_fault_line_1_i),
    .sync_o(line1_s)
  );

  // Qualification: line must stay low for the full 10 us
  always @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      qual_cnt0 <= 32'h0;
      qual_cnt1 <= 32'h0;
    end else begin
      if (line0_s)
        qual_cnt0 <= 32'h0;
      else if (qual_cnt0 < QUAL_CYC)
        qual_cnt0 <= qual_cnt0 + 32'h1;
      if (line1_s)
        qual_cnt1 <= 32'h0;
      else if (qual_cnt1 < QUAL_CYC)
        qual_cnt1 <= qual_cnt1 + 32'h1;
    end
  end
  assign qual_low = {(qual_cnt1 >= QUAL_CYC), (qual_cnt0 >= QUAL_CYC)};

  // Channel 0
  frc_chan #(
    .QUIET_CYC(QUIET_CYC),
    .STEP_CYC(STEP_CYC)
  ) u_ch0 (
    .sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i),
    .chan_on_cmd_i(chan_on_cmd_i[0]),
    .local_fault_i(local_fault_i[0]),
    .fault_retry_field_i(fault_retry_field_i[2:0]),
    .retry_delay_steps_i(retry_delay_steps_i),
    .retry_limit_i(retry_lim),
    .line_resp_i({resp1[0], resp0[0]}),
    .line_qual_low_i(qual_low),
    .line_low_i({~line1_s, ~line0_s}),
    .chan_enable_o(chan_enable_o[0]),
    .faulted_off_o(ch_fo[0]),
    .line_shutdown_o(),
    .line_shut_event_o(ev0),
    .retries_used_o(used0)
  );

  // Channel 1
  frc_chan #(
    .QUIET_CYC(QUIET_CYC),
    .STEP_CYC(STEP_CYC)
  ) u_ch1 (
    .sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i),
    .chan_on_cmd_i(chan_on_cmd_i[1]),
    .local_fault_i(local_fault_i[1]),
    .fault_retry_field_i(fault_retry_field_i[5:3]),
    .retry_delay_steps_i(retry_delay_steps_i),
    .retry_limit_i(retry_lim),
    .line_resp_i({resp1[1], resp0[1]}),
    .line_qual_low_i(qual_low),
    .line_low_i({~line1_s, ~line0_s}),
    .chan_enable_o(chan_enable_o[1]),
    .faulted_off_o(ch_fo[1]),
    .line_shutdown_o(),
    .line_shut_event_o(ev1),
    .retries_used_o(used1)
  );

  assign faulted_off_o = ch_fo;

  // Open drain: output is always low, enable pulls the line
  assign shared_fault_line_0_o = 1'b0;
  assign shared_fault_line_1_o = 1'b0;
  assign shared_fault_line_0_oe_o = |(ch_fo & prop0);
  assign shared_fault_line_1_oe_o = |(ch_fo & prop1);

  // Sticky status per channel; a new event wins over a clear
  always @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      mfr_line_stat_ch0_o <= 2'h0;
      mfr_line_stat_ch1_o <= 2'h0;
    end else begin
      mfr_line_stat_ch0_o <= (status_clear_i ? 2'h0 : mfr_line_stat_ch0_o) | ev0;
      mfr_line_stat_ch1_o <= (status_clear_i ? 2'h0 : mfr_line_stat_ch1_o) | ev1;
    end
  end

  // Alert is low while any status bit stands
  assign host_alert_line_n_o = ~(|{mfr_line_stat_ch0_o, mfr_line_stat_ch1_o});

endmodule // frc_top
`default_nettype wire
